// [design/dma_status_block.sv]
// DMA channel status, priority arbitration, interrupt vectoring and board configuration
`timescale 1ns/1ps
`include "dma_status_map.svh"

module dma_status_block (
    input  wire logic                           clk,
    input  wire logic                           nrst,
    input  wire logic [9:0]                     reg_addr,
    input  wire logic [7:0]                     reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output logic [7:0]                          reg_rdata,
    input  wire dma_status_pkg::chan_event_t [3:0] chan_event,
    input  wire logic [3:0]                     svc_req,
    output logic                                grant_valid,
    output logic [1:0]                          grant_ch,
    input  wire logic                           hold_mode,
    input  wire logic                           operand_done,
    output logic                                bus_hold,
    output logic                                bus_release,
    output logic [6:0]                          vme_irq,
    input  wire logic                           iack_strobe,
    input  wire logic [2:0]                     iack_level,
    output logic                                iack_ack,
    output logic [7:0]                          iack_vector,
    output logic [1:0]                          port_status_irq,
    output dma_status_pkg::board_cfg_t          board_cfg
);

    typedef struct packed {
        dma_status_pkg::chan_state_t [3:0] ch;
        dma_status_pkg::board_cfg_t        cfg;
        logic [3:0]                        hold_reg;
        logic [1:0]                        svc_last;
        logic [1:0]                        irq_last;
        logic                              gnt_v;
        logic [1:0]                        gnt_ch;
        logic                              held;
        logic [6:0]                        irq_out;
        logic                              ack;
        logic [7:0]                        vec;
        logic [1:0]                        port_irq;
        logic [7:0]                        rdata;
    } block_state_t;

    block_state_t state_reg;
    block_state_t state_next;
    logic [3:0]   irq_pend;
    logic [2:0]   svc_pick;
    logic [2:0]   irq_pick;
    logic         release_pulse;
    logic [1:0]   a_ch;
    logic [5:0]   a_off;
    logic         chan_space;

    // Highest priority first, round robin from the last winner among ties
    function automatic logic [2:0] pick(input logic [3:0] req,
                                        input dma_status_pkg::chan_state_t [3:0] ch,
                                        input logic [1:0] last);
        logic [1:0] best;
        logic [1:0] c;
        logic [2:0] res;
        best = 2'h0;
        res  = 3'h0;
        for (int i = 0; i < 4; i++) begin
            if (req[i] && ch[i].prio > best) begin
                best = ch[i].prio;
            end
        end
        for (int k = 4; k >= 1; k--) begin
            c = 2'(last + 2'(k));
            if (req[c] && ch[c].prio == best) begin
                res = {1'b1, c};
            end
        end
        return res;
    endfunction

    // Burst time decode: 16, 32, 64 or 128 clocks
    function automatic logic [7:0] burst_clocks(input logic [1:0] bt);
        return 8'(`BURST_BASE_CLKS << bt);
    endfunction

    assign a_ch       = reg_addr[7:6];
    assign a_off      = reg_addr[5:0];
    assign chan_space = (reg_addr[9:8] == 2'h0) && (reg_addr != `ADDR_BUS_HOLD);

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            irq_pend[i] = state_reg.ch[i].irq_en && (state_reg.ch[i].done
                          || state_reg.ch[i].block
                          || (state_reg.ch[i].pcl_fall && state_reg.ch[i].pcl_irq));
        end
    end

    assign svc_pick = pick(svc_req, state_reg.ch, state_reg.svc_last);
    assign irq_pick = pick(irq_pend, state_reg.ch, state_reg.irq_last);

    // one timer shared by every channel
    // Each operand as well as each request restarts the idle count
    hold_interval_timer u_hold (
        .clk                   (clk),
        .nrst                  (nrst),
        .holding               (state_reg.held),
        .activity              (|svc_req || operand_done),
        .burst_time_field      (state_reg.hold_reg[3:2]),
        .bandwidth_share_field (state_reg.hold_reg[1:0]),
        .release_pulse         (release_pulse)
    );

    // Next-state logic for registers, arbitration and acknowledge
    always_comb begin
        state_next       = state_reg;
        state_next.ack   = 1'b0;
        state_next.gnt_v = svc_pick[2];
        if (svc_pick[2]) begin
            state_next.gnt_ch   = svc_pick[1:0];
            state_next.svc_last = svc_pick[1:0];
        end

        // Software writes; status flags clear by writing one
        if (reg_wr && chan_space) begin
            unique case (a_off)
                `OFF_CHAN_STATUS: begin
                    if (reg_wdata[`CSR_DONE_BIT]) state_next.ch[a_ch].done = 1'b0;
                    if (reg_wdata[`CSR_BLOCK_BIT]) state_next.ch[a_ch].block = 1'b0;
                    if (reg_wdata[`CSR_PCL_FALL_BIT]) state_next.ch[a_ch].pcl_fall = 1'b0;
                    if (reg_wdata[`CSR_FAULT_BIT]) begin
                        state_next.ch[a_ch].fault = 1'b0;
                        state_next.ch[a_ch].code  = `CODE_NONE;
                    end
                end
                `OFF_CHAN_CONTROL: state_next.ch[a_ch].irq_en = reg_wdata[`CCR_IRQ_EN_BIT];
                `OFF_PCL_MODE:     state_next.ch[a_ch].pcl_irq = reg_wdata[0];
                `OFF_NORMAL_VECTOR: state_next.ch[a_ch].nvec = reg_wdata;
                `OFF_FAULT_VECTOR:  state_next.ch[a_ch].fvec = reg_wdata;
                `OFF_PRIORITY:     state_next.ch[a_ch].prio = reg_wdata[1:0];
                default: ;
            endcase
        end
        if (reg_wr && reg_addr == `ADDR_BUS_HOLD) begin
            state_next.hold_reg = reg_wdata[3:0];
        end
        // shared board bits, separate direction per port
        if (reg_wr && (reg_addr == `ADDR_CFG1_A || reg_addr == `ADDR_CFG1_B)) begin
            state_next.cfg.irq_sel  = reg_wdata[`CFG_IRQ_MSB:`CFG_IRQ_LSB];
            state_next.cfg.brg_sel  = reg_wdata[`CFG_BRG_MSB:`CFG_BRG_LSB];
            state_next.cfg.carry_en = reg_wdata[`CFG_CARRY_BIT];
            state_next.cfg.ror_dis  = reg_wdata[`CFG_ROR_BIT];
            if (reg_addr == `ADDR_CFG1_A) begin
                state_next.cfg.dir_a = reg_wdata[`CFG_DIR_BIT];
            end else begin
                state_next.cfg.dir_b = reg_wdata[`CFG_DIR_BIT];
            end
        end

        // event capture; set wins over a same-cycle clear
        for (int i = 0; i < 4; i++) begin
            if (chan_event[i].done_set) state_next.ch[i].done = 1'b1;
            if (chan_event[i].block_set) state_next.ch[i].block = 1'b1;
            if (chan_event[i].pcl_fall_set) state_next.ch[i].pcl_fall = 1'b1;
            if (chan_event[i].fault_set) begin
                state_next.ch[i].fault = 1'b1;
                state_next.ch[i].code  = chan_event[i].fault_code;
            end
        end

        if (iack_strobe && state_reg.cfg.irq_sel != 3'h0
            && iack_level == state_reg.cfg.irq_sel && irq_pick[2]) begin
            state_next.ack      = 1'b1;
            state_next.irq_last = irq_pick[1:0];
            state_next.vec = state_reg.ch[irq_pick[1:0]].fault
                           ? state_reg.ch[irq_pick[1:0]].fvec
                           : state_reg.ch[irq_pick[1:0]].nvec;
        end

        state_next.irq_out = '0;
        if (|irq_pend && state_reg.cfg.irq_sel != 3'h0) begin
            state_next.irq_out[3'(state_reg.cfg.irq_sel - 3'h1)] = 1'b1;
        end
        // status channels of the two ports
        state_next.port_irq = {irq_pend[3], irq_pend[1]};

        // keep the bus after an operand until idle
        // A fresh operand beats a release in the same cycle, so no transfer loses the bus
        if (hold_mode && operand_done) begin
            state_next.held = 1'b1;
        end else if (release_pulse || !hold_mode) begin
            state_next.held = 1'b0;
        end

        // Read data; write-only and unmapped addresses read zero
        if (reg_rd) begin
            state_next.rdata = 8'h00;
            if (reg_addr == `ADDR_BUS_HOLD) begin
                state_next.rdata = {4'h0, state_reg.hold_reg};
            end else if (chan_space) begin
                unique case (a_off)
                    `OFF_CHAN_STATUS: state_next.rdata = {state_reg.ch[a_ch].done,
                        state_reg.ch[a_ch].block, 1'b0, state_reg.ch[a_ch].fault,
                        chan_event[a_ch].active, 1'b0, state_reg.ch[a_ch].pcl_fall, 1'b0};
                    `OFF_FAULT_CODE:    state_next.rdata = {3'h0, state_reg.ch[a_ch].code};
                    `OFF_CHAN_CONTROL:  state_next.rdata = {4'h0, state_reg.ch[a_ch].irq_en,
                                                            3'h0};
                    `OFF_PCL_MODE:      state_next.rdata = {7'h00, state_reg.ch[a_ch].pcl_irq};
                    `OFF_NORMAL_VECTOR: state_next.rdata = state_reg.ch[a_ch].nvec;
                    `OFF_FAULT_VECTOR:  state_next.rdata = state_reg.ch[a_ch].fvec;
                    `OFF_PRIORITY:      state_next.rdata = {6'h00, state_reg.ch[a_ch].prio};
                    default:            state_next.rdata = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_reg <= '0;
            for (int i = 0; i < 4; i++) begin
                state_reg.ch[i].nvec <= `VECTOR_RESET;
                state_reg.ch[i].fvec <= `VECTOR_RESET;
            end
            state_reg.cfg.irq_sel <= `IRQ_SEL_RESET;
            state_reg.cfg.brg_sel <= `BRG_SEL_RESET;
            state_reg.cfg.ror_dis <= `ROR_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata       = state_reg.rdata;
    assign grant_valid     = state_reg.gnt_v;
    assign grant_ch        = state_reg.gnt_ch;
    assign bus_hold        = state_reg.held;
    assign bus_release     = release_pulse;
    assign vme_irq         = state_reg.irq_out;
    assign iack_ack        = state_reg.ack;
    assign iack_vector     = state_reg.vec;
    assign port_status_irq = state_reg.port_irq;
    assign board_cfg       = state_reg.cfg;

    // burst length decode; the timer works from the exponent instead
    logic [7:0] burst_len;
    assign burst_len = burst_clocks(state_reg.hold_reg[3:2]);

    // Interval equals burst length times two to the share field plus one
    a_interval_decode: assert property (@(posedge clk) disable iff (!nrst)
        (12'(burst_len) << (4'(state_reg.hold_reg[1:0]) + 4'h1))
        == 12'(u_hold.limit + 12'h001))
        else $error("Hold interval disagrees with burst decode");

    a_vector_reset: assert property (@(posedge clk)
        !nrst |=> state_reg.ch[0].nvec == 8'h0f && state_reg.ch[3].fvec == 8'h0f)
        else $error("Vectors not 0x0f after reset");

    a_cfg_reset: assert property (@(posedge clk)
        !nrst |=> board_cfg.ror_dis && board_cfg.irq_sel == 3'h0 && !board_cfg.dir_a)
        else $error("Board configuration reset values wrong");

    a_code_readonly: assert property (@(posedge clk) disable iff (!nrst)
        reg_wr && chan_space && a_off == `OFF_FAULT_CODE && !chan_event[a_ch].fault_set
        |=> state_reg.ch[$past(a_ch)].code == $past(state_reg.ch[a_ch].code))
        else $error("Fault code changed by a write");

    a_code_clear: assert property (@(posedge clk) disable iff (!nrst)
        reg_wr && chan_space && a_off == `OFF_CHAN_STATUS && reg_wdata[4] && a_ch == 2'h0
        && !chan_event[0].fault_set |=> state_reg.ch[0].code == 5'h00 && !state_reg.ch[0].fault)
        else $error("Fault code not cleared with flag");

    a_iack_mismatch: assert property (@(posedge clk) disable iff (!nrst)
        iack_strobe && iack_level != board_cfg.irq_sel |=> !iack_ack)
        else $error("Acknowledge on wrong level");

    a_iack_match: assert property (@(posedge clk) disable iff (!nrst)
        iack_strobe && board_cfg.irq_sel != 3'h0 && iack_level == board_cfg.irq_sel
        && |irq_pend |=> iack_ack)
        else $error("Matching acknowledge not answered");

    a_grant_prio: assert property (@(posedge clk) disable iff (!nrst)
        svc_req[3] && state_reg.ch[3].prio == 2'h3 |=> grant_valid
        && state_reg.ch[grant_ch].prio == 2'h3)
        else $error("Lower priority channel granted");

    a_irq_line: assert property (@(posedge clk) disable iff (!nrst)
        board_cfg.irq_sel == 3'h0 |=> vme_irq == 7'h00)
        else $error("Interrupt line driven with none selected");

    a_dir_separate: assert property (@(posedge clk) disable iff (!nrst)
        reg_wr && reg_addr == `ADDR_CFG1_B |=> $stable(board_cfg.dir_a)
        && board_cfg.carry_en == $past(reg_wdata[2]))
        else $error("Port B write disturbed port A direction");

    c_iack_fault: cover property (@(posedge clk) disable iff (!nrst)
        iack_ack && iack_vector == state_reg.ch[state_reg.irq_last].fvec);
    c_tie_grant: cover property (@(posedge clk) disable iff (!nrst)
        svc_req == 4'hf ##1 svc_req == 4'hf ##1 grant_valid);
    c_hold_cycle: cover property (@(posedge clk) disable iff (!nrst)
        bus_hold ##[1:300] !bus_hold);

endmodule

// [design/dma_status_map.svh]
// Register offsets, field positions, reset values and timing counts of the DMA status block
`ifndef DMA_STATUS_MAP_SVH
`define DMA_STATUS_MAP_SVH

// Channel registers: address = channel * 0x40 + offset
`define OFF_CHAN_STATUS   6'h00
`define OFF_FAULT_CODE    6'h01
`define OFF_PCL_MODE      6'h05
`define OFF_CHAN_CONTROL  6'h07
`define OFF_NORMAL_VECTOR 6'h25
`define OFF_FAULT_VECTOR  6'h27
`define OFF_PRIORITY      6'h2d
`define ADDR_BUS_HOLD     10'h0ff
`define ADDR_CFG1_A       10'h101
`define ADDR_CFG1_B       10'h301

// Channel status and control bits
`define CSR_DONE_BIT      7
`define CSR_BLOCK_BIT     6
`define CSR_FAULT_BIT     4
`define CSR_ACTIVE_BIT    3
`define CSR_PCL_FALL_BIT  1
`define CCR_IRQ_EN_BIT    3

// Configuration register one fields
`define CFG_IRQ_MSB       7
`define CFG_IRQ_LSB       5
`define CFG_BRG_MSB       4
`define CFG_BRG_LSB       3
`define CFG_CARRY_BIT     2
`define CFG_ROR_BIT       1
`define CFG_DIR_BIT       0

// Reset values
`define VECTOR_RESET      8'h0f
`define IRQ_SEL_RESET     3'h0
`define BRG_SEL_RESET     2'h0
`define ROR_RESET         1'h1
`define CODE_NONE         5'h00

// Hold sample interval exponent offset and base burst length
`define HOLD_EXP_BASE     4'h5
`define BURST_BASE_CLKS   8'h10

`endif

// [design/dma_status_pkg.sv]
// Types shared by the DMA status, priority and bus configuration block
package dma_status_pkg;

    // Fault codes of a channel
    typedef enum logic [4:0] {
        FAULT_NONE     = 5'h00,
        FAULT_CONFIG   = 5'h01,
        FAULT_TIMING   = 5'h02,
        FAULT_ADDR_MEM = 5'h05,
        FAULT_ADDR_DEV = 5'h06,
        FAULT_ADDR_BAS = 5'h07,
        FAULT_BUS_MEM  = 5'h09,
        FAULT_BUS_DEV  = 5'h0a,
        FAULT_BUS_BAS  = 5'h0b,
        FAULT_CNT_MEM  = 5'h0d,
        FAULT_CNT_DEV  = 5'h0e,
        FAULT_CNT_BAS  = 5'h0f,
        FAULT_EXT_ABRT = 5'h10,
        FAULT_SW_ABRT  = 5'h11
    } fault_code_t;

    // Per-channel event strobes from the transfer engine
    typedef struct packed {
        logic        done_set;
        logic        block_set;
        logic        pcl_fall_set;
        logic        active;
        logic        fault_set;
        fault_code_t fault_code;
    } chan_event_t;

    // Per-channel register state
    typedef struct packed {
        logic        done;
        logic        block;
        logic        fault;
        logic        pcl_fall;
        logic        irq_en;
        logic        pcl_irq;
        logic [1:0]  prio;
        logic [4:0]  code;
        logic [7:0]  nvec;
        logic [7:0]  fvec;
    } chan_state_t;

    // Board configuration outputs
    typedef struct packed {
        logic [2:0] irq_sel;
        logic [1:0] brg_sel;
        logic       carry_en;
        logic       ror_dis;
        logic       dir_a;
        logic       dir_b;
    } board_cfg_t;

endpackage

// [design/hold_interval_timer.sv]
// Bus hold sample interval timer shared by all four channels
`timescale 1ns/1ps
`include "dma_status_map.svh"

module hold_interval_timer (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       holding,
    input  wire logic       activity,
    input  wire logic [1:0] burst_time_field,
    input  wire logic [1:0] bandwidth_share_field,
    output logic            release_pulse
);

    typedef struct packed {
        logic [11:0] cnt;
        logic        rel;
    } timer_state_t;

    timer_state_t state_reg;
    timer_state_t state_next;
    logic [11:0]  limit;

    // interval of 2^(burst + bandwidth + 5) clocks, at most 2048
    assign limit = 12'(12'h001 << (4'(burst_time_field) + 4'(bandwidth_share_field)
                                   + `HOLD_EXP_BASE)) - 12'h001;

    always_comb begin
        state_next     = state_reg;
        state_next.rel = 1'b0;
        if (!holding || activity) begin
            state_next.cnt = 12'h000;
        end else if (state_reg.cnt == limit) begin
            state_next.rel = 1'b1;
            state_next.cnt = 12'h000;
        end else begin
            state_next.cnt = state_reg.cnt + 12'h001;
        end
    end

    // Synchronous reset register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign release_pulse = state_reg.rel;

    a_hold_release_time: assert property (@(posedge clk) disable iff (!nrst)
        state_reg.rel |-> $past(state_reg.cnt) == $past(limit))
        else $error("Hold release before full sample interval");

    c_hold_release: cover property (@(posedge clk) disable iff (!nrst) state_reg.rel);

endmodule

// [tb/host_model.sv]
// Host model: register bus cycles and interrupt acknowledge cycles
`timescale 1ns/1ps
module host_model (
    input  wire logic       clk,
    output logic [9:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata,
    output logic            iack_strobe,
    output logic [2:0]      iack_level,
    input  wire logic       iack_ack,
    input  wire logic [7:0] iack_vector
);
    // Idle bus from time zero
    initial begin
        reg_addr = 10'h000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        iack_strobe = 1'b0;
        iack_level = 3'h0;
    end
    // Write launched at a falling edge, taken by the next rising edge
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    // Read data is registered, so it is sampled one cycle after the strobe
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
    // A refused level never answers, so the wait is cut after a few cycles
    task automatic iack(input logic [2:0] l, output logic ok, output logic [7:0] v);
        @(negedge clk);
        iack_strobe = 1'b1;
        iack_level = l;
        @(negedge clk);
        iack_strobe = 1'b0;
        ok = 1'b0;
        v = 8'h00;
        repeat (3) begin
            if (iack_ack === 1'b1) begin
                ok = 1'b1;
                v = iack_vector;
            end
            @(negedge clk);
        end
    endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench of the DMA status, arbitration and board configuration block
`timescale 1ns/1ps
module testbench;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [9:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic [39:0] ev = 40'h0;
    logic [3:0]  svc_req = 4'h0;
    logic        grant_valid;
    logic [1:0]  grant_ch;
    logic        hold_mode = 1'b0;
    logic        operand_done = 1'b0;
    logic        bus_hold;
    logic        bus_release;
    logic [6:0]  vme_irq;
    logic        iack_strobe;
    logic [2:0]  iack_level;
    logic        iack_ack;
    logic [7:0]  iack_vector;
    logic [1:0]  port_status_irq;
    logic [8:0]  board_cfg;
    logic [31:0] seed = 32'hee3b;
    int          n_errors = 0;
    int          n_tests = 0;
    int          cycles = 0;
    int          prio [4];
    int          last = 0;

    dma_status_block dma_status_block_inst (
        .clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .chan_event(ev), .svc_req, .grant_valid, .grant_ch, .hold_mode,
        .operand_done, .bus_hold, .bus_release, .vme_irq, .iack_strobe,
        .iack_level, .iack_ack, .iack_vector, .port_status_irq, .board_cfg
    );
    host_model host_model_inst (
        .clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .iack_strobe, .iack_level, .iack_ack, .iack_vector
    );

    always #5 clk = ~clk;
    // Hang guard, well above the expected run of some 1100 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Model: top priority wins, ties go to the first channel after the last grant
    function automatic int arb(input logic [3:0] req);
        int g;
        int c;
        g = -1;
        for (int k = 1; k <= 4; k++) begin
            c = (last + k) % 4;
            if (req[c] && (g < 0 || prio[c] > prio[g]))
                g = c;
        end
        if (g >= 0)
            last = g;
        return g;
    endfunction
    // Event strobes last exactly one cycle
    task automatic pulse(input logic [39:0] v);
        @(negedge clk);
        ev = v;
        @(negedge clk);
        ev = 40'h0;
    endtask
    task automatic ack_chk(input logic [2:0] l, input logic [15:0] exp);
        logic       ok;
        logic [7:0] v;
        host_model_inst.iack(l, ok, v);
        chk({7'h0, ok, v}, exp, "acknowledge");
    endtask

    initial begin
        logic [7:0] d;
        logic [7:0] e;
        int         g;
        int         n;
        dma_status_pkg::fault_code_t f;
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        chk(16'(board_cfg), 16'h004, "config reset");
        for (int c = 0; c < 4; c++) begin
            host_model_inst.rd(10'(c * 64 + 37), d);
            chk(16'(d), 16'h0f, "normal vector reset");
            host_model_inst.rd(10'(c * 64 + 39), d);
            chk(16'(d), 16'h0f, "fault vector reset");
        end
        $display("test reset done");
        // priority storage and grant order under random requests
        for (int c = 0; c < 4; c++) begin
            d = 8'(rnd());
            prio[c] = int'(d[1:0]);
            host_model_inst.wr(10'(c * 64 + 45), d);
            host_model_inst.rd(10'(c * 64 + 45), e);
            chk(16'(e), 16'(prio[c]), "priority readback");
        end
        for (int i = 0; i < 60; i++) begin
            svc_req = 4'(rnd());
            @(negedge clk);
            g = arb(svc_req);
            chk(16'(grant_valid), 16'(g >= 0), "grant valid");
            if (g >= 0)
                chk(16'(grant_ch), 16'(g), "granted channel");
        end
        svc_req = 4'h0;
        $display("test arbitration done");
        // shared bits follow the last writer, direction stays per port
        for (int i = 0; i < 6; i++) begin
            d = 8'(rnd());
            e = 8'(rnd());
            host_model_inst.wr(10'h101, d);
            chk(16'(board_cfg[8:1]), 16'(d), "port a config");
            host_model_inst.wr(10'h301, e);
            chk(16'(board_cfg), 16'({e[7:1], d[0], e[0]}), "port b config");
        end
        $display("test config done");
        // code loads on a fault, ignores writes, clears with flag
        f = f.first();
        do begin
            n = int'(f) % 4;
            pulse(40'(10'h020 | 10'(f)) << (10 * n));
            host_model_inst.wr(10'(n * 64 + 1), 8'hff);
            host_model_inst.rd(10'(n * 64 + 1), d);
            chk(16'(d), 16'(f), "fault code");
            host_model_inst.rd(10'(n * 64), d);
            chk(16'(d), 16'h10, "fault flag");
            host_model_inst.wr(10'(n * 64), 8'h10);
            host_model_inst.rd(10'(n * 64 + 1), d);
            chk(16'(d), 16'h00, "code cleared");
            f = f.next();
        end while (f != f.first());
        $display("test fault codes done");
        // vectoring on line three, channel 3 above channel 1
        host_model_inst.wr(10'h101, 8'h62);
        host_model_inst.wr(10'h06d, 8'h01);
        host_model_inst.wr(10'h0ed, 8'h03);
        for (int c = 1; c < 4; c += 2) begin
            host_model_inst.wr(10'(c * 64 + 37), 8'(8'h40 + c));
            host_model_inst.wr(10'(c * 64 + 39), 8'(8'h80 + c));
            host_model_inst.wr(10'(c * 64 + 7), 8'h08);
        end
        pulse({20'h0, 10'h200, 10'h200});
        repeat (2) @(negedge clk);
        chk(16'(vme_irq), 16'h04, "irq line");
        chk(16'(port_status_irq), 16'h1, "port irq");
        ack_chk(3'h2, 16'h000);
        ack_chk(3'h3, 16'h141);
        pulse({20'h0, 10'h031, 10'h0});
        ack_chk(3'h3, 16'h181);
        pulse({10'h100, 30'h0});
        repeat (2) @(negedge clk);
        chk(16'(port_status_irq), 16'h3, "port irq");
        ack_chk(3'h3, 16'h143);
        host_model_inst.wr(10'h0c0, 8'hff);
        ack_chk(3'h3, 16'h181);
        host_model_inst.wr(10'h040, 8'hff);
        host_model_inst.wr(10'h000, 8'hff);
        repeat (2) @(negedge clk);
        chk(16'(vme_irq), 16'h00, "irq cleared");
        pulse({20'h0, 10'h080, 10'h0});
        repeat (2) @(negedge clk);
        chk(16'(vme_irq), 16'h00, "line fall, mode off");
        host_model_inst.wr(10'h045, 8'h01);
        repeat (2) @(negedge clk);
        chk(16'(vme_irq), 16'h04, "line fall, mode on");
        host_model_inst.wr(10'h040, 8'h02);
        $display("test interrupts done");
        // idle interval of two to burst plus share plus five
        for (int i = 0; i < 3; i++) begin
            d = 8'(i * 5);
            n = 1 << (d[3:2] + d[1:0] + 5);
            host_model_inst.wr(10'h0ff, 8'hf0 | d);
            host_model_inst.rd(10'h0ff, e);
            chk(16'(e), 16'(d), "hold control");
            @(negedge clk);
            hold_mode = 1'b1;
            operand_done = 1'b1;
            @(negedge clk);
            operand_done = 1'b0;
            g = 0;
            while (bus_release !== 1'b1 && g < n + 8) begin
                @(negedge clk);
                g++;
            end
            chk(16'(g >= n - 1 && g <= n + 3), 16'h1, "hold interval");
            chk(16'(bus_hold), 16'h1, "bus held");
            @(negedge clk);
            hold_mode = 1'b0;
        end
        // A request inside the interval restarts it, so the bus stays held
        host_model_inst.wr(10'h0ff, 8'h00);
        hold_mode = 1'b1;
        operand_done = 1'b1;
        @(negedge clk);
        operand_done = 1'b0;
        repeat (20) @(negedge clk);
        svc_req = 4'h8;
        @(negedge clk);
        svc_req = 4'h0;
        repeat (20) @(negedge clk);
        chk(16'(bus_hold), 16'h1, "hold after restart");
        hold_mode = 1'b0;
        $display("test bus hold done");
        summarize();
    end
endmodule
